// *** cable_ts_pkg.sv ***
// Shared constants and carrier types for the cable transport stream channel coder
`default_nettype none
package cable_ts_pkg;
    // ------------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------------
    localparam int          TS_LEN        = 188;      // Transport packet bytes
    localparam int          CW_LEN        = 204;      // Codeword bytes
    localparam int          PAR_LEN       = 16;       // Parity bytes per codeword
    localparam int          RS_PAD_ZEROS  = 51;       // Leading zero bytes of the long code
    localparam logic [7:0]  SYNC_BYTE     = 8'h47;
    localparam logic [7:0]  SYNC_INV      = 8'hB8;
    localparam logic [2:0]  GROUP_LAST    = 3'h7;     // Eight packets per scrambling group
    // ------------------------------------------------------------------
    // Randomiser and field
    // ------------------------------------------------------------------
    localparam logic [14:0] PRBS_INIT     = 15'h00A9; // Stage 1 in bit 0 .. stage 15 in bit 14
    localparam logic [7:0]  GF_POLY_LOW   = 8'h1D;    // Low byte of the field polynomial
    localparam logic [7:0]  RS_ALPHA      = 8'h02;
    // ------------------------------------------------------------------
    // Interleaver and receive lock
    // ------------------------------------------------------------------
    localparam int          INTL_BRANCHES = 12;
    localparam int          INTL_CELLS    = 17;
    localparam logic [1:0]  LOCK_MISS_MAX = 2'h3;     // Missed syncs before re-hunting

    typedef enum logic [1:0] {
        HUNT   = 2'b01,
        LOCKED = 2'b10
    } lock_e;

    typedef struct packed {
        logic       sync;
        logic [7:0] data;
    } ts_byte_s;

    typedef struct packed {
        logic [14:0] state;
        logic [7:0]  seq;
    } prbs_step_s;
endpackage
`default_nettype wire

// *** cable_ts_channel_coder.sv ***
// Channel coder (scramble, RS(204,188), interleave) and matching receive path
`default_nettype none

// ----------------------------------------------------------------------
// Convolutional branch FIFO bank, forward or reversed delays
// ----------------------------------------------------------------------
module conv_branch_fifo
    import cable_ts_pkg::*;
#(
    parameter int BRANCHES = INTL_BRANCHES,
    parameter int CELLS    = INTL_CELLS,
    parameter bit REVERSE  = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       step,
    input  wire logic       restart,
    input  wire logic [7:0] in_data,
    output logic      [7:0] out_data
);
    localparam int MEM_DEPTH = CELLS * BRANCHES * (BRANCHES - 1) / 2;
    localparam int AW        = $clog2(MEM_DEPTH);

    logic [7:0]                   mem [MEM_DEPTH];
    logic [BRANCHES-1:0][7:0]     ptr_q;
    logic [BRANCHES-1:0][7:0]     ptr_d;
    logic [3:0]                   br_q;
    logic [3:0]                   br_d;
    logic [3:0]                   br;
    logic [3:0]                   dly;
    logic [AW-1:0]                addr;

    // Branches are packed back to back; branch of delay d starts here
    function automatic logic [AW-1:0] fifo_base(input logic [3:0] d);
        int b;
        b = CELLS * int'(d) * (int'(d) - 1) / 2;
        return b[AW-1:0];
    endfunction

    // Switch position, delay and cell address
    always_comb begin
        br       = restart ? 4'h0 : br_q;
        dly      = REVERSE ? 4'(BRANCHES - 1 - int'(br)) : br;
        addr     = fifo_base(dly) + AW'(ptr_q[br]);
        out_data = (dly == 4'h0) ? in_data : mem[addr];
        br_d     = br_q;
        ptr_d    = ptr_q;
        if (step) begin
            br_d = (int'(br) == BRANCHES - 1) ? 4'h0 : br + 4'h1;
            if (dly != 4'h0) begin
                ptr_d[br] = (int'(ptr_q[br]) == int'(dly) * CELLS - 1) ? 8'h00 : ptr_q[br] + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            br_q  <= 4'h0;
            ptr_q <= '0;
        end else begin
            br_q  <= br_d;
            ptr_q <= ptr_d;
        end
    end

    // Cell storage; read-before-write gives exactly d*CELLS of delay
    always_ff @(posedge clock) begin
        if (step && dly != 4'h0) begin
            mem[addr] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Top: transmit coder and receive de-interleaver / descrambler
// ----------------------------------------------------------------------
// Function
// - Bits handled MSB first from sync byte
// - Fifteen-stage PRBS, taps at stages 14, 15
// - PRBS reloaded every eighth packet
// - First sync of group sent inverted
// - First PRBS bit hits byte after B8
// - Later syncs step PRBS but stay clear
// - Scrambling ignores input framing, pauses while input idle
// - Sixteen parity bytes make 204-byte codeword
// - Sync byte included in parity computation
// - Roots alpha^0..15, field x8+x4+x3+x2+1
// - Shortened code, 51 zero lead bytes
// - Twelve branches, branch j holds 17j
// - Output keeps sync every 204 bytes
// - Every transmitted sync goes through zero-delay branch; received syncs take the longest de-interleaver branch
// - De-interleaver reversed, aligns on first sync
module cable_ts_channel_coder
    import cable_ts_pkg::*;
#(
    parameter int BRANCHES = INTL_BRANCHES,
    parameter int CELLS    = INTL_CELLS
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output ts_byte_s        enc_out,
    output logic            enc_valid,
    output logic            in_ready,
    input  wire logic       dec_in_valid,
    input  wire logic [7:0] dec_in_data,
    output ts_byte_s        dec_out,
    output logic            dec_valid,
    output logic            dec_locked
);
    if (BRANCHES * CELLS != CW_LEN || CELLS * (BRANCHES - 1) > 256 || BRANCHES > 16) begin : g_bad_shape
        $error("Interleaver shape must give a 204-byte frame with short branches");
    end

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    // Field multiply, reduction by the field polynomial
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY_LOW) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    // Generator coefficients, product of (x + alpha^i), i = 0..15
    function automatic logic [PAR_LEN-1:0][7:0] rs_gen();
        logic [PAR_LEN:0][7:0] g;
        logic [7:0]            root;
        g    = '0;
        g[0] = 8'h01;
        root = 8'h01;
        for (int i = 0; i < PAR_LEN; i++) begin
            for (int k = PAR_LEN; k > 0; k--) begin
                g[k] = g[k-1] ^ gf_mul(g[k], root);
            end
            g[0] = gf_mul(g[0], root);
            root = gf_mul(root, RS_ALPHA);
        end
        return g[PAR_LEN-1:0];
    endfunction

    localparam logic [PAR_LEN-1:0][7:0] RS_G = rs_gen();

    // Eight PRBS steps; first bit out lands on data bit 7
    function automatic prbs_step_s prbs_byte(input logic [14:0] s);
        prbs_step_s r;
        logic       fb;
        r.state = s;
        r.seq   = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            fb       = r.state[13] ^ r.state[14];
            r.seq[i] = fb;
            r.state  = {r.state[13:0], fb};
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Transmit: scrambler and RS encoder
    // ------------------------------------------------------------------
    logic [7:0]              pos_q, pos_d;
    logic [2:0]              grp_q, grp_d;
    logic [14:0]             prbs_q, prbs_d;
    logic [PAR_LEN-1:0][7:0] par_q, par_d;
    logic [PAR_LEN-1:0][7:0] par_base;
    logic                    ready_q, ready_d;
    logic                    step;
    logic [7:0]              coded;
    logic [7:0]              fb;
    prbs_step_s              rnd;
    logic [7:0]              intl_out;
    ts_byte_s                enc_q, enc_d;
    logic                    enc_valid_q;

    // Position is counted here, never taken from the input, so a
    // broken stream cannot halt scrambling; idle input only pauses it
    always_comb begin
        rnd      = prbs_byte(prbs_q);
        pos_d    = pos_q;
        grp_d    = grp_q;
        prbs_d   = prbs_q;
        par_d    = par_q;
        coded    = 8'h00;
        fb       = 8'h00;
        par_base = '0;
        step     = (int'(pos_q) < TS_LEN) ? (in_valid && ready_q) : 1'b1;
        if (step) begin
            pos_d = (int'(pos_q) == CW_LEN - 1) ? 8'h00 : pos_q + 8'h01;
            if (int'(pos_q) == CW_LEN - 1) begin
                grp_d = grp_q + 3'h1;                                   // wraps after GROUP_LAST
            end
            if (int'(pos_q) >= TS_LEN) begin
                coded = par_q[PAR_LEN-1];
                par_d = {par_q[PAR_LEN-2:0], 8'h00};
            end else begin
                if (pos_q == 8'h00) begin
                    if (grp_q == 3'h0) begin
                        coded  = ~in_data;
                        prbs_d = PRBS_INIT;
                    end else begin
                        coded  = in_data;
                        prbs_d = rnd.state;
                    end
                end else begin
                    coded  = in_data ^ rnd.seq;
                    prbs_d = rnd.state;
                end
                // Zero lead bytes leave the register at zero: clearing it at
                // the sync byte is the same as feeding them
                par_base = (pos_q == 8'h00) ? '0 : par_q;
                fb       = coded ^ par_base[PAR_LEN-1];
                par_d[0] = gf_mul(fb, RS_G[0]);
                for (int i = 1; i < PAR_LEN; i++) begin
                    par_d[i] = par_base[i-1] ^ gf_mul(fb, RS_G[i]);
                end
            end
        end
        ready_d   = int'(pos_d) < TS_LEN;
        enc_d     = enc_q;
        if (step) begin
            enc_d.data = intl_out;
            enc_d.sync = pos_q == 8'h00;
        end
    end

    // Codeword byte 0 always restarts the switch, so syncs take branch 0
    conv_branch_fifo #(
        .BRANCHES (BRANCHES),
        .CELLS    (CELLS),
        .REVERSE  (1'b0)
    ) u_interleave (
        .clock    (clock),
        .rst      (rst),
        .step     (step),
        .restart  (step && pos_q == 8'h00),
        .in_data  (coded),
        .out_data (intl_out)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pos_q       <= 8'h00;
            grp_q       <= 3'h0;
            prbs_q      <= PRBS_INIT;
            par_q       <= '0;
            ready_q     <= 1'b1;
            enc_q       <= '0;
            enc_valid_q <= 1'b0;
        end else begin
            pos_q       <= pos_d;
            grp_q       <= grp_d;
            prbs_q      <= prbs_d;
            par_q       <= par_d;
            ready_q     <= ready_d;
            enc_q       <= enc_d;
            enc_valid_q <= step;
        end
    end

    assign enc_out   = enc_q;
    assign enc_valid = enc_valid_q;
    assign in_ready  = ready_q;

    // ------------------------------------------------------------------
    // Receive: sync hunt, de-interleaver, descrambler
    // ------------------------------------------------------------------
    lock_e       lock_q, lock_d;
    logic [1:0]  miss_q, miss_d;
    logic [7:0]  dpos_q, dpos_d;
    logic [7:0]  cur_pos;
    logic [14:0] dprbs_q, dprbs_d;
    logic        sync_hit;
    logic        resync;
    logic [7:0]  dint_out;
    prbs_step_s  drnd;
    ts_byte_s    dec_q, dec_d;
    logic        dec_valid_q, dec_valid_d;

    // Both delay banks sum to a whole number of frames, so the
    // de-interleaved byte shares the input's frame position
    always_comb begin
        sync_hit    = dec_in_valid && (dec_in_data == SYNC_BYTE || dec_in_data == SYNC_INV);
        resync      = lock_q == HUNT && sync_hit;
        cur_pos     = resync ? 8'h00 : dpos_q;
        drnd        = prbs_byte(dprbs_q);
        lock_d      = lock_q;
        miss_d      = miss_q;
        dpos_d      = dpos_q;
        dprbs_d     = dprbs_q;
        dec_d       = dec_q;
        dec_valid_d = 1'b0;
        unique case (lock_q)
            HUNT: begin
                if (resync) begin
                    lock_d = LOCKED;
                    miss_d = 2'h0;
                end
            end
            LOCKED: begin
                if (dec_in_valid && cur_pos == 8'h00) begin
                    if (sync_hit) begin
                        miss_d = 2'h0;
                    end else if (miss_q == LOCK_MISS_MAX - 2'h1) begin
                        lock_d = HUNT;
                    end else begin
                        miss_d = miss_q + 2'h1;
                    end
                end
            end
        endcase
        if (dec_in_valid) begin
            dpos_d = (int'(cur_pos) == CW_LEN - 1) ? 8'h00 : cur_pos + 8'h01;
            if (int'(cur_pos) < TS_LEN) begin
                dec_valid_d = lock_q == LOCKED || resync;
                dec_d.sync  = cur_pos == 8'h00;
                if (cur_pos == 8'h00) begin
                    if (dint_out == SYNC_INV) begin
                        dec_d.data = SYNC_BYTE;
                        dprbs_d    = PRBS_INIT;
                    end else begin
                        dec_d.data = dint_out;
                        dprbs_d    = drnd.state;
                    end
                end else begin
                    dec_d.data = dint_out ^ drnd.seq;
                    dprbs_d    = drnd.state;
                end
            end
        end
    end

    conv_branch_fifo #(
        .BRANCHES (BRANCHES),
        .CELLS    (CELLS),
        .REVERSE  (1'b1)
    ) u_deinterleave (
        .clock    (clock),
        .rst      (rst),
        .step     (dec_in_valid),
        .restart  (resync),
        .in_data  (dec_in_data),
        .out_data (dint_out)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_q      <= HUNT;
            miss_q      <= 2'h0;
            dpos_q      <= 8'h00;
            dprbs_q     <= PRBS_INIT;
            dec_q       <= '0;
            dec_valid_q <= 1'b0;
        end else begin
            lock_q      <= lock_d;
            miss_q      <= miss_d;
            dpos_q      <= dpos_d;
            dprbs_q     <= dprbs_d;
            dec_q       <= dec_d;
            dec_valid_q <= dec_valid_d;
        end
    end

    assign dec_out    = dec_q;
    assign dec_valid  = dec_valid_q;
    assign dec_locked = lock_q[1];                                      // One-hot LOCKED bit, straight from the flop
endmodule
`default_nettype wire

// *** cable_ts_chk.sv ***
// Port checker for the cable transport stream coder, bound into the top
`default_nettype none
module cable_ts_chk
    import cable_ts_pkg::*;
#(
    parameter int BRANCHES = INTL_BRANCHES,
    parameter int CELLS    = INTL_CELLS
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       in_valid,
    input wire logic [7:0] in_data,
    input wire ts_byte_s   enc_out,
    input wire logic       enc_valid,
    input wire logic       in_ready,
    input wire logic       dec_in_valid,
    input wire logic [7:0] dec_in_data,
    input wire ts_byte_s   dec_out,
    input wire logic       dec_valid,
    input wire logic       dec_locked
);
    // -----------
    // Frame count
    // -----------
    logic [7:0] cnt_q, cnt_d;
    logic [2:0] grp_q, grp_d;
    logic       seen_q, seen_d;
    // Bytes since the last marker, markers since reset modulo eight
    always_comb begin
        cnt_d  = cnt_q;
        grp_d  = grp_q;
        seen_d = seen_q;
        if (enc_valid) begin
            cnt_d  = enc_out.sync ? 8'h00 : cnt_q + 8'h01;
            grp_d  = grp_q + {2'h0, enc_out.sync};
            seen_d = seen_q | enc_out.sync;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q  <= 8'h00;
            grp_q  <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            grp_q  <= grp_d;
            seen_q <= seen_d;
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_sync_period: assert property (enc_valid && seen_q |-> enc_out.sync == (cnt_q == 8'hCB))
        else $error("marker spacing wrong");
    a_group_marker: assert property (enc_valid && enc_out.sync |->
        enc_out.data == (grp_q == 3'h0 ? SYNC_INV : SYNC_BYTE))
        else $error("marker byte wrong");
    a_parity_gap: assert property ($fell(in_ready) |-> !in_ready [*8] ##1 !in_ready [*8] ##1 in_ready)
        else $error("parity gap not sixteen");
    a_parity_flow: assert property (!in_ready |-> enc_valid)
        else $error("no byte during parity");
    a_take_answer: assert property (in_valid && in_ready |=> enc_valid)
        else $error("taken byte not answered");
    a_hunt_sync: assert property (!dec_locked && dec_in_valid && (dec_in_data == SYNC_BYTE ||
        dec_in_data == SYNC_INV) |=> dec_locked && dec_valid && dec_out.sync)
        else $error("no lock on marker");
    a_dec_answer: assert property (dec_valid |-> $past(dec_in_valid))
        else $error("decoded byte without input");
    a_hunt_quiet: assert property (!dec_locked && !$past(dec_locked) |-> !dec_valid)
        else $error("output while hunting");
    c_parity: cover property ($fell(in_ready));
    c_group: cover property (enc_valid && enc_out.sync && enc_out.data == SYNC_INV);
    c_lost: cover property ($fell(dec_locked));
endmodule

bind cable_ts_channel_coder cable_ts_chk #(.BRANCHES(BRANCHES), .CELLS(CELLS)) u_chk (
    .clock, .rst, .in_valid, .in_data, .enc_out, .enc_valid, .in_ready,
    .dec_in_valid, .dec_in_data, .dec_out, .dec_valid, .dec_locked
);
`default_nettype wire

// *** ts_source_model.sv ***
// Upstream multiplexer model: whole packets with random idle gaps
`default_nettype none
module ts_source_model
    import cable_ts_pkg::*;
#(
    parameter int NPKT = 20
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       in_ready,
    output logic            in_valid,
    output logic      [7:0] in_data,
    output logic            fire,
    output logic            done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] lfsr = 32'h2A9E;
    int          pos  = 0;
    int          cnt  = 0;
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial {in_valid, in_data, fire} = 10'h000;
    assign done = (cnt == NPKT);
    // Offer a byte and hold it until taken; fire predicts the next edge
    always @(negedge clock) begin
        lfsr = next_rand(lfsr);
        if (rst) begin
            in_valid = 1'b0;
            pos = 0;
            cnt = 0;
        end else begin
            if (fire) begin
                pos = (pos + 1) % TS_LEN; // 188-byte packets
                if (pos == 0) cnt++;
            end
            if (fire || !in_valid) begin
                in_valid = (cnt < NPKT) && (lfsr[1:0] != 2'h0);
                in_data = !in_valid ? ~in_data : (pos == 0) ? SYNC_BYTE : lfsr[15:8]; // Sync first
            end
        end
        fire = in_valid && in_ready && !rst;
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench: coded stream, loopback decode, lock loss and resync
`default_nettype none
module tb import cable_ts_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NPKT = 20;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       direct = 1'b0;
    logic       dec_in_valid = 1'b0;
    logic [7:0] dec_in_data = 8'h00;
    logic       in_valid, in_ready, enc_valid, dec_valid, dec_locked, fire, done;
    logic [7:0] in_data;
    ts_byte_s   enc_out, dec_out;
    logic [7:0] exp_q[NPKT*CW_LEN];
    logic [7:0] orig[NPKT*TS_LEN];
    logic [7:0] gen[16];
    logic [7:0] par[16];
    logic [14:0] pr;
    int fails = 0, check_count = 0, ntake, ncode, nout, dp, dpos, cyc = 0;

    cable_ts_channel_coder DUT (.clock, .rst, .in_valid, .in_data, .enc_out, .enc_valid, .in_ready,
        .dec_in_valid, .dec_in_data, .dec_out, .dec_valid, .dec_locked);
    ts_source_model #(.NPKT(NPKT)) src (.clock, .rst, .in_ready, .in_valid, .in_data, .fire, .done);

    always #20 clock = ~clock;

    // -------
    // Helpers
    // -------
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Field product, reduced by the field polynomial
    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) r = r ^ a;
            a = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY_LOW : 8'h00); // Field
        end
        return r;
    endfunction
    // Eight sequence steps, MSB first; gate low leaves the byte clear
    function automatic logic [7:0] scr(input logic [7:0] b, input logic gate);
        logic o;
        for (int i = 7; i >= 0; i--) begin
            o = pr[13] ^ pr[14]; // Taps
            pr = {pr[13:0], o};
            b[i] = b[i] ^ (o & gate); // Bit order
        end
        return b;
    endfunction
    // Expected coded bytes for one taken byte, parity after byte 187
    task automatic code_byte(input logic [7:0] b, input int p, input int k);
        logic [7:0] c, fb;
        if (p == 0 && k % 8 == 0) begin
            pr = PRBS_INIT; // Reload
            c = ~b; // Inverted marker
        end else begin
            c = scr(b, p != 0); // First bit after marker
        end
        if (p == 0) par = '{default: 8'h00}; // Zero lead bytes leave it clear
        fb = c ^ par[15]; // Marker is coded too
        for (int i = 15; i > 0; i--) par[i] = par[i-1] ^ gm(fb, gen[i]);
        par[0] = gm(fb, gen[0]);
        exp_q[ncode] = c;
        ncode++;
        if (p == TS_LEN - 1) for (int i = 15; i >= 0; i--) begin
            exp_q[ncode] = par[i]; // Sixteen parity bytes
            ncode++;
        end
    endtask
    task automatic rx_byte(input logic [7:0] b);
        dec_in_valid <= 1'b1;
        dec_in_data  <= b;
        @(negedge clock);
    endtask

    // --------
    // Monitors
    // --------
    // Taken bytes feed the reference; fire is settled since the last fall
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_sim();
        end
        if (!rst && fire) begin
            orig[ntake] = in_data;
            code_byte(in_data, ntake % TS_LEN, ntake / TS_LEN);
            ntake++;
        end
    end
    // Outputs sampled mid-cycle; loopback copies the line, else shows inverse
    always @(negedge clock) begin
        if (!rst && enc_valid) begin
            if (nout >= nout % INTL_BRANCHES * CW_LEN)
                check(enc_out, {nout % CW_LEN == 0, exp_q[nout - nout % INTL_BRANCHES * CW_LEN]});
            nout++;
        end
        if (!rst && dec_valid && !direct) begin
            dpos = dec_out.sync ? 0 : dpos + 1;
            dp = dp + dec_out.sync;
            if (dp >= 11) check(dec_out, {dpos == 0, orig[(dp - 11) * TS_LEN + dpos]});
        end
        if (!direct) begin
            dec_in_valid <= enc_valid;
            dec_in_data  <= enc_valid ? enc_out.data : ~dec_in_data;
        end
    end

    // -------------
    // Main sequence
    // -------------
    initial begin
        logic [7:0] g[17];
        logic [7:0] a;
        g = '{default: 8'h00};
        g[0] = 8'h01;
        a = 8'h01;
        for (int i = 0; i < 16; i++) begin
            for (int j = 16; j > 0; j--) g[j] = g[j-1] ^ gm(g[j], a); // Consecutive roots
            g[0] = gm(g[0], a);
            a = gm(a, RS_ALPHA);
        end
        for (int i = 0; i < 16; i++) gen[i] = g[i];
        // Second pass resets after the first run has ended, while the decoder is still locked
        for (int r = 0; r < 2; r++) begin
            @(negedge clock);
            rst <= 1'b1;
            dec_in_valid <= 1'b0;
            repeat (20) @(negedge clock);
            check({in_ready, enc_valid, dec_valid, dec_locked, 5'h00}, 9'h100);
            check(enc_out, 9'h000);
            check(dec_out, 9'h000);
            {ntake, ncode, nout, dpos, dp} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
            rst <= 1'b0;
            while (!done) @(posedge clock);
            repeat (30) @(posedge clock);
            direct = 1'b1;
            @(negedge clock);
            // Lose lock on dead markers, regain it on either marker value
            for (int s = 0; s < 2; s++) begin
                repeat (4 * CW_LEN) rx_byte(8'h00);
                check({8'h00, dec_locked}, 9'h000); // Misses drop lock
                rx_byte(s == 0 ? SYNC_INV : SYNC_BYTE);
                check({7'h00, dec_locked, dec_valid}, 9'h003);
                // The marker rides the longest branch, so it leaves eleven frames later
                for (int k = 1; k <= 11 * CW_LEN; k++) rx_byte(k % CW_LEN == 0 ? SYNC_BYTE : 8'h00);
                check({8'h00, dec_locked}, 9'h001); // Syncs every frame hold lock
                check(dec_out, {1'b1, SYNC_BYTE}); // Marker restored
            end
            dec_in_valid <= 1'b0;
            @(posedge clock);
            direct = 1'b0;
        end
        end_sim();
    end
endmodule
`default_nettype wire
